// ---- src/interlock_logic_engine.sv ----
// Interlock logic engine: APB registers, mode control, auxiliary inputs 8-17,
// pulse timing and output drive. Assumes all pins are synchronous to pclk.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "ile_defs.svh"
// Behaviour
// - Program lines 200 to 300, one instruction each, addressed by line number.
// - Program lines change only in setting mode.
// - After reset every program line holds an end instruction.
// - Entering operation mode checks syntax; a bad program keeps setting mode.
// - Output write to a temporary cell stores the accumulator.
// - Operand 61 always reads one.
// - Test bypass switch set enables every open and close operation.
// - Interlock use cleared means all open and close operations enabled.
// - Interlock gates controlled outputs only, never protection trips.
// - Direct control drives outputs from the program result while it holds.
// - Codes 220-231 select open/close pairs, 40 and 41 the signal outputs.
// - Direct control follows the interlock lines and shares one end.
// - Indicators 8-13 follow inputs; memory mode latches after 10 ms active.
// - Per-channel polarity: 1 active high, 0 active low, default high.
// - Each status change of channels 8-17 raises an event.
// - A channel drives one signal output and activates or inhibits one control.
// - Input-driven control still checks interlock, ignores the local/remote key.
// - Input-driven signals follow the input; control pulses last the set length.
// - Program is evaluated every 20 ms in operation mode.
// - Mode 0 is setting, no execution; mode 1 is operation.
// - Operands map closed, undefined, open and active status codes.
// - Operand 60 reads zero, 62 the key, 70-89 are temporary cells.
module interlock_logic_engine
	import ile_pkg::*;
#(
	parameter int TICK_CYCLES = `ILE_TICK_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [6:0]  obj_closed,
	input  wire logic [6:0]  obj_open,
	input  wire logic [9:0]  aux_in,
	input  wire logic        key_remote,
	input  wire logic [5:0]  prot_trip,
	output logic      [5:0]  open_out,
	output logic      [5:0]  close_out,
	output logic             signal_out_a,
	output logic             signal_out_b,
	output logic      [5:0]  led_out
);
	localparam int CH = `ILE_CHANNELS;
	localparam int NL = `ILE_LEDS;
	localparam int EVAL_TICKS = `ILE_EVAL_MS * 1000 / `ILE_TICK_US;
	localparam int LATCH_TICKS = `ILE_LED_LATCH_MS * 1000 / `ILE_TICK_US;

	prog_if pif ();

	logic [2:0]  ctrl_r;
	logic        op_mode_r;
	logic        syntax_err_r;
	logic [9:0]  polarity_r;
	logic [5:0]  led_mem_r;
	logic [5:0]  led_latched_r;
	logic [9:0]  open_len_r;
	logic [9:0]  close_len_r;
	logic [9:0]  event_r;
	logic [7:0]  sel_a_r [CH];
	logic [7:0]  sel_b_r [CH];
	logic [CH-1:0] inh_sel_r;
	logic [9:0]  act_r;
	logic [9:0]  act_d_r;
	logic [16:0] tick_cnt_r;
	logic        ms_tick;
	logic [4:0]  eval_cnt_r;
	logic [11:0] cmd_req_r;
	logic [11:0] trig;
	logic [11:0] inh;
	logic [11:0] enable;
	logic [11:0] pulse_on;
	logic [11:0] ctl_r;
	logic [1:0]  sig_drv;
	logic [1:0]  sig_r;
	logic [3:0]  bj;
	logic [31:0] rd_nxt;
	logic        mapped;
	logic        setup;
	logic        wr;
	logic        il_use;
	logic        bypass;
	logic [9:0]  rise;
	logic        is_prog;
	logic        is_iosel;
	logic [6:0]  prog_line;
	logic [3:0]  io_ch;

	assign il_use = ctrl_r[`ILE_CTRL_IL_USE];
	assign bypass = ctrl_r[`ILE_CTRL_BYPASS];
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign prog_line = paddr[8:2];
	assign io_ch = paddr[5:2];
	assign is_prog = (paddr[11:9] == 3'h2) && (prog_line < 7'(`ILE_PROG_LINES));
	assign is_iosel = (paddr[11:6] == 6'h01) && (io_ch < 4'(CH));

	// Zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		mapped = 1'b1;
		if (is_prog) begin
			rd_nxt = {16'h0000, pif.rd_data};
		end else if (is_iosel) begin
			rd_nxt = {15'h0000, inh_sel_r[io_ch], sel_b_r[io_ch], sel_a_r[io_ch]};
		end else begin
			unique case (paddr)
				`ILE_OFS_CTRL:       rd_nxt = {29'h0, ctrl_r};
				`ILE_OFS_STATUS:     rd_nxt = {28'h0, op_mode_r && !pif.busy && 1'b0,
					!op_mode_r && il_use, syntax_err_r, op_mode_r};
				`ILE_OFS_POLARITY:   rd_nxt = {22'h0, polarity_r};
				`ILE_OFS_LEDCFG:     rd_nxt = {26'h0, led_mem_r};
				`ILE_OFS_LEDCLR:     rd_nxt = {26'h0, led_latched_r};
				`ILE_OFS_PULSE_OPEN: rd_nxt = {22'h0, open_len_r};
				`ILE_OFS_PULSE_CLS:  rd_nxt = {22'h0, close_len_r};
				`ILE_OFS_EVENT:      rd_nxt = {22'h0, event_r};
				`ILE_OFS_INSTATE:    rd_nxt = {10'h0, led_out, 6'h00, act_r};
				`ILE_OFS_OUTSTATE:   rd_nxt = {14'h0, sig_r, 2'h0, close_out, 2'h0, open_out};
				`ILE_OFS_CMD:        rd_nxt = 32'h0000_0000;
				default:             mapped = 1'b0;
			endcase
		end
	end

	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_nxt;
		end
	end

	// Program port: lines accepted only outside operation and outside a check or pass
	assign pif.wr_en = wr && is_prog && !op_mode_r && !pif.busy;
	assign pif.wr_line = prog_line;
	assign pif.wr_data = prog_word_t'(pwdata[15:0]);
	assign pif.rd_line = is_prog ? prog_line : 7'h00;
	assign pif.closed = obj_closed;
	assign pif.opened = obj_open;
	assign pif.active = act_r;
	assign pif.key_remote = key_remote;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `ILE_CTRL_RST;
			polarity_r <= `ILE_POL_RST;
			led_mem_r <= 6'h00;
			open_len_r <= `ILE_PULSE_RST;
			close_len_r <= `ILE_PULSE_RST;
			inh_sel_r <= '0;
			for (int c = 0; c < CH; c++) begin
				sel_a_r[c] <= 8'h00;
				sel_b_r[c] <= 8'h00;
			end
		end else if (wr && mapped) begin
			if (is_iosel) begin
				sel_a_r[io_ch] <= pwdata[7:0];
				sel_b_r[io_ch] <= pwdata[15:8];
				inh_sel_r[io_ch] <= pwdata[`ILE_IOSEL_INH];
			end else begin
				unique case (paddr)
					`ILE_OFS_CTRL:       ctrl_r <= pwdata[2:0];
					`ILE_OFS_POLARITY:   polarity_r <= pwdata[9:0];
					`ILE_OFS_LEDCFG:     led_mem_r <= pwdata[5:0];
					`ILE_OFS_PULSE_OPEN: open_len_r <= pwdata[9:0];
					`ILE_OFS_PULSE_CLS:  close_len_r <= pwdata[9:0];
					default: ;
				endcase
			end
		end
	end

	// A check starts when software asks for operation mode with interlock use set while in setting mode
	assign pif.check_start = wr && (paddr == `ILE_OFS_CTRL) && pwdata[`ILE_CTRL_RUN]
		&& pwdata[`ILE_CTRL_IL_USE] && !op_mode_r && !pif.busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_mode_r <= 1'b0;
			syntax_err_r <= 1'b0;
		end else begin
			if (pif.check_start) begin
				syntax_err_r <= 1'b0;
			end else if (pif.check_done) begin
				syntax_err_r <= !pif.check_ok;
			end
			// Without interlocks in use the engine can never run
			if (!ctrl_r[`ILE_CTRL_RUN] || !il_use) begin
				op_mode_r <= 1'b0;
			end else if (pif.check_done && pif.check_ok) begin
				op_mode_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 17'h00000;
			eval_cnt_r <= 5'h00;
		end else begin
			tick_cnt_r <= ms_tick ? 17'h00000 : tick_cnt_r + 17'h00001;
			if (ms_tick) begin
				eval_cnt_r <= (eval_cnt_r == 5'(EVAL_TICKS - 1)) ? 5'h00 : eval_cnt_r + 5'h01;
			end
		end
	end
	assign ms_tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));
	// A pass that is still running when the next 20 ms slot comes is not restarted
	assign pif.eval_start = ms_tick && (eval_cnt_r == 5'(EVAL_TICKS - 1)) && op_mode_r
		&& !pif.busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_r <= 10'h000;
			act_d_r <= 10'h000;
			event_r <= 10'h000;
			cmd_req_r <= 12'h000;
		end else begin
			act_r <= ~(aux_in ^ polarity_r);
			act_d_r <= act_r;
			// New changes win over a clear in the same cycle
			event_r <= (event_r & ~((wr && paddr == `ILE_OFS_EVENT) ? pwdata[9:0] : 10'h000))
				| (act_r ^ act_d_r);
			cmd_req_r <= (wr && paddr == `ILE_OFS_CMD)
				? {pwdata[13:8], pwdata[5:0]} : 12'h000;
		end
	end
	assign rise = act_r & ~act_d_r;

	always_comb begin
		trig = 12'h000;
		inh = 12'h000;
		sig_drv = 2'h0;
		bj = 4'h0;
		for (int c = 0; c < CH; c++) begin
			if ({1'b0, sel_b_r[c]} >= `ILE_OUT_IL_LO && {1'b0, sel_b_r[c]} <= `ILE_OUT_IL_HI) begin
				bj = 4'(sel_b_r[c] - 8'h14);
				if (inh_sel_r[c]) begin
					inh[bj] = inh[bj] | act_r[c];
				end else begin
					trig[bj] = trig[bj] | rise[c];
				end
			end
			if ({1'b0, sel_a_r[c]} == `ILE_SIG_A) begin
				sig_drv[0] = sig_drv[0] | act_r[c];
			end
			if ({1'b0, sel_a_r[c]} == `ILE_SIG_B) begin
				sig_drv[1] = sig_drv[1] | act_r[c];
			end
		end
		// Serial commands are mapped onto the same even-open, odd-close order
		for (int k = 0; k < 6; k++) begin
			trig[2*k] = trig[2*k] | cmd_req_r[k];
			trig[2*k+1] = trig[2*k+1] | cmd_req_r[6+k];
		end
		// The key position is not consulted for any of these requests
		enable = {12{bypass || !il_use}} | ({12{op_mode_r}} & pif.il_en);
		// Input inhibits only count while interlocks are in use
		inh = inh & {12{il_use}};
	end

	generate
		for (genvar j = 0; j < 12; j++) begin : g_ctl
			logic [16:0] cnt_r;
			logic [9:0]  len;
			assign len = (j % 2 != 0) ? close_len_r : open_len_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_r <= 17'h00000;
				end else if (trig[j] && enable[j] && !inh[j] && cnt_r == 17'h00000) begin
					cnt_r <= 17'(len) * 17'(`ILE_PULSE_UNIT_MS);
				end else if (ms_tick && cnt_r != 17'h00000) begin
					cnt_r <= cnt_r - 17'h00001;
				end
			end
			assign pulse_on[j] = (cnt_r != 17'h00000);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctl_r[j] <= 1'b0;
				end else begin
					// Direct control holds only while the last pass enabled it
					ctl_r[j] <= (pulse_on[j] || (op_mode_r && pif.dc_en[2+j])) && !inh[j];
				end
			end
		end
		for (genvar k = 0; k < 6; k++) begin : g_pair
			// Protection trips bypass every gate on the way out
			assign open_out[k] = ctl_r[2*k] || prot_trip[k];
			assign close_out[k] = ctl_r[2*k+1];
		end
		for (genvar l = 0; l < NL; l++) begin : g_led
			logic [3:0] on_cnt_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					on_cnt_r <= 4'h0;
				end else if (!act_r[l]) begin
					on_cnt_r <= 4'h0;
				end else if (ms_tick && on_cnt_r != 4'(LATCH_TICKS)) begin
					on_cnt_r <= on_cnt_r + 4'h1;
				end
			end
			// Reaching the hold time wins over a clear in the same cycle
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					led_latched_r[l] <= 1'b0;
				end else if (on_cnt_r == 4'(LATCH_TICKS)) begin
					led_latched_r[l] <= 1'b1;
				end else if (wr && paddr == `ILE_OFS_LEDCLR && pwdata[l]) begin
					led_latched_r[l] <= 1'b0;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					led_out[l] <= 1'b0;
				end else begin
					led_out[l] <= act_r[l] || (led_mem_r[l] && led_latched_r[l]);
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_r <= 2'h0;
		end else begin
			sig_r <= sig_drv | ({2{op_mode_r}} & pif.dc_en[1:0]);
		end
	end
	assign signal_out_a = sig_r[0];
	assign signal_out_b = sig_r[1];

	logic_program_runner #(
		.LINES (`ILE_PROG_LINES)
	) u_runner (
		.clk   (pclk),
		.rst_n (presetn),
		.pif   (pif.runner)
	);
endmodule : interlock_logic_engine

// ---- pkg/ile_defs.svh ----
// Constants of the interlock logic engine: register offsets, field positions,
// reset values, operand codes and timing. Assumes APB with 32-bit data at 100 MHz.
`ifndef ILE_DEFS_SVH
`define ILE_DEFS_SVH
`define ILE_CLK_HZ         100000000
`define ILE_TICK_US        1000
`define ILE_TICK_CYCLES    (`ILE_CLK_HZ / 1000000 * `ILE_TICK_US)
`define ILE_EVAL_MS        20
`define ILE_LED_LATCH_MS   10
`define ILE_PULSE_UNIT_MS  100
`define ILE_FIRST_LINE     200
`define ILE_LAST_LINE      300
`define ILE_PROG_LINES     (`ILE_LAST_LINE - `ILE_FIRST_LINE + 1)
`define ILE_CHANNELS       10
`define ILE_LEDS           6
`define ILE_OFS_CTRL       12'h000
`define ILE_OFS_STATUS     12'h004
`define ILE_OFS_POLARITY   12'h008
`define ILE_OFS_LEDCFG     12'h00c
`define ILE_OFS_LEDCLR     12'h010
`define ILE_OFS_PULSE_OPEN 12'h014
`define ILE_OFS_PULSE_CLS  12'h018
`define ILE_OFS_EVENT      12'h01c
`define ILE_OFS_INSTATE    12'h020
`define ILE_OFS_OUTSTATE   12'h024
`define ILE_OFS_CMD        12'h028
`define ILE_OFS_IOSEL      12'h040
`define ILE_OFS_PROG       12'h400
`define ILE_CTRL_RUN       0
`define ILE_CTRL_IL_USE    1
`define ILE_CTRL_BYPASS    2
`define ILE_IOSEL_INH      16
`define ILE_CTRL_RST       3'h2
`define ILE_POL_RST        10'h3ff
`define ILE_PULSE_RST      10'h00a
`define ILE_OPD_ZERO       9'h03c
`define ILE_OPD_ONE        9'h03d
`define ILE_OPD_KEY        9'h03e
`define ILE_OPD_TEMP_LO    9'h046
`define ILE_OPD_TEMP_HI    9'h059
`define ILE_OPD_ACT_LO     9'h008
`define ILE_OPD_ACT_HI     9'h011
`define ILE_OPD_UNDEF_LO   9'h065
`define ILE_OPD_OPEN_LO    9'h0c9
`define ILE_OUT_IL_LO      9'h014
`define ILE_OUT_IL_HI      9'h01f
`define ILE_OUT_DC_LO      9'h0dc
`define ILE_OUT_DC_HI      9'h0e7
`define ILE_SIG_A          9'h028
`define ILE_SIG_B          9'h029
`endif

// ---- pkg/ile_pkg.sv ----
// Types of the interlock logic engine: instruction word and runner states.
// Shared by the controller, the runner and the interface between them.
package ile_pkg;
	typedef enum logic [3:0] {
		OP_END        = 4'h0,
		OP_LOAD       = 4'h1,
		OP_LOAD_INV   = 4'h2,
		OP_AND        = 4'h3,
		OP_AND_INV    = 4'h4,
		OP_OR         = 4'h5,
		OP_OR_INV     = 4'h6,
		OP_OUT        = 4'h7
	} opcode_t;

	typedef struct packed {
		logic [3:0] op;
		logic [2:0] rsvd;
		logic [8:0] operand;
	} prog_word_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_CHECK = 2'h1,
		ST_RUN   = 2'h2
	} run_state_t;

	localparam int DEST_N = 46;
endpackage : ile_pkg

// ---- pkg/prog_if.sv ----
// Link between the engine controller and the program runner.
// Assumes one clock domain; the controller drives requests, the runner answers.
`timescale 1ns/1ps
interface prog_if;
	import ile_pkg::*;
	logic        wr_en;
	logic [6:0]  wr_line;
	prog_word_t  wr_data;
	logic [6:0]  rd_line;
	prog_word_t  rd_data;
	logic        check_start;
	logic        check_done;
	logic        check_ok;
	logic        eval_start;
	logic        busy;
	logic [6:0]  closed;
	logic [6:0]  opened;
	logic [9:0]  active;
	logic        key_remote;
	logic [11:0] il_en;
	logic [13:0] dc_en;
	modport ctrl (output wr_en, wr_line, wr_data, rd_line, check_start, eval_start,
		closed, opened, active, key_remote,
		input rd_data, check_done, check_ok, busy, il_en, dc_en);
	modport runner (input wr_en, wr_line, wr_data, rd_line, check_start, eval_start,
		closed, opened, active, key_remote,
		output rd_data, check_done, check_ok, busy, il_en, dc_en);
endinterface : prog_if

// ---- src/logic_program_runner.sv ----
// Program store, syntax check and evaluation pass of the interlock logic engine.
// Assumes lines are only written in setting mode and passes follow a good check.
`timescale 1ns/1ps
`include "ile_defs.svh"
module logic_program_runner
	import ile_pkg::*;
#(
	parameter int LINES = `ILE_PROG_LINES
) (
	input wire logic clk,
	input wire logic rst_n,
	prog_if.runner   pif
);
	prog_word_t        mem_r [LINES];
	run_state_t        st_r;
	logic [6:0]        pc_r;
	logic              acc_r;
	logic              prev_out_r;
	logic [DEST_N-1:0] used_r;
	logic [DEST_N-1:0] shadow_r;
	logic [25:0]       out_r;
	logic [19:0]       temp_r;
	prog_word_t        w;
	logic [5:0]        d;
	logic              dv;
	logic              sv;
	logic              val;
	logic              loadish;
	logic              bad;

	function automatic logic [6:0] dest_idx(input logic [8:0] c);
		if (c >= `ILE_OUT_IL_LO && c <= `ILE_OUT_IL_HI) return {1'b1, 6'(c - `ILE_OUT_IL_LO)};
		if (c == `ILE_SIG_A || c == `ILE_SIG_B) return {1'b1, 6'(c - `ILE_SIG_A + 9'h00c)};
		if (c >= `ILE_OUT_DC_LO && c <= `ILE_OUT_DC_HI) return {1'b1, 6'(c - `ILE_OUT_DC_LO + 9'h00e)};
		if (c >= `ILE_OPD_TEMP_LO && c <= `ILE_OPD_TEMP_HI)
			return {1'b1, 6'(c - `ILE_OPD_TEMP_LO + 9'h01a)};
		return 7'h00;
	endfunction : dest_idx

	function automatic logic [1:0] src_read(input logic [8:0] c);
		if (c >= 9'h001 && c <= 9'h007) return {1'b1, pif.closed[3'(c - 9'h001)]};
		if (c >= `ILE_OPD_UNDEF_LO && c < `ILE_OPD_UNDEF_LO + 9'h007)
			return {1'b1, pif.closed[3'(c - `ILE_OPD_UNDEF_LO)] == pif.opened[3'(c - `ILE_OPD_UNDEF_LO)]};
		if (c >= `ILE_OPD_OPEN_LO && c < `ILE_OPD_OPEN_LO + 9'h007)
			return {1'b1, pif.opened[3'(c - `ILE_OPD_OPEN_LO)]};
		if (c >= `ILE_OPD_ACT_LO && c <= `ILE_OPD_ACT_HI)
			return {1'b1, pif.active[4'(c - `ILE_OPD_ACT_LO)]};
		if (c == `ILE_OPD_ZERO) return 2'h2;
		if (c == `ILE_OPD_ONE) return 2'h3;
		if (c == `ILE_OPD_KEY) return {1'b1, pif.key_remote};
		if (c >= `ILE_OPD_TEMP_LO && c <= `ILE_OPD_TEMP_HI)
			return {1'b1, temp_r[5'(c - `ILE_OPD_TEMP_LO)]};
		return 2'h0;
	endfunction : src_read

	always_comb begin
		w = mem_r[pc_r];
		{dv, d} = dest_idx(w.operand);
		{sv, val} = src_read(w.operand);
		loadish = (w.op == OP_LOAD) || (w.op == OP_LOAD_INV);
		// Syntax check of one line against the lines before it
		bad = (w.op > OP_OUT)
			|| (pc_r == 7'h00 && !loadish)
			|| (w.op == OP_END && (pc_r == 7'h00 || !prev_out_r))
			|| (loadish && pc_r != 7'h00 && !prev_out_r)
			|| (w.op == OP_OUT && (!dv || used_r[d]))
			|| (w.op != OP_OUT && w.op != OP_END && !sv)
			|| (pc_r == 7'(LINES - 1) && w.op != OP_END);
	end

	// Every line starts as an end instruction writes only arrive in setting mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LINES; i++) begin
				mem_r[i] <= '0;
			end
		end else if (pif.wr_en) begin
			mem_r[pif.wr_line] <= pif.wr_data;
		end
	end
	assign pif.rd_data = mem_r[pif.rd_line];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			pc_r <= 7'h00;
			acc_r <= 1'b0;
			prev_out_r <= 1'b0;
			used_r <= '0;
			shadow_r <= '0;
			out_r <= '0;
			temp_r <= '0;
			pif.check_done <= 1'b0;
			pif.check_ok <= 1'b0;
		end else begin
			pif.check_done <= 1'b0;
			unique case (st_r)
				ST_IDLE: begin
					pc_r <= 7'h00;
					prev_out_r <= 1'b0;
					used_r <= '0;
					shadow_r <= '0;
					if (pif.check_start) begin
						st_r <= ST_CHECK;
					end else if (pif.eval_start) begin
						st_r <= ST_RUN;
					end
				end
				ST_CHECK: begin
					if (bad || w.op == OP_END) begin
						pif.check_done <= 1'b1;
						pif.check_ok <= !bad;
						st_r <= ST_IDLE;
					end else begin
						pc_r <= pc_r + 7'h01;
						prev_out_r <= (w.op == OP_OUT);
						if (w.op == OP_OUT) begin
							used_r[d] <= 1'b1;
						end
					end
				end
				ST_RUN: begin
					pc_r <= pc_r + 7'h01;
					unique case (w.op)
						OP_LOAD:     acc_r <= val;
						OP_LOAD_INV: acc_r <= !val;
						OP_AND:      acc_r <= acc_r & val;
						OP_AND_INV:  acc_r <= acc_r & !val;
						OP_OR:       acc_r <= acc_r | val;
						OP_OR_INV:   acc_r <= acc_r | !val;
						OP_OUT: begin
							if (d >= 6'h1a) begin
								temp_r[5'(d - 6'h1a)] <= acc_r;
							end else begin
								shadow_r[d] <= acc_r;
							end
						end
						default: begin
							// One shared end closes both programs; unwritten enables read 0
							out_r <= shadow_r[25:0];
							st_r <= ST_IDLE;
						end
					endcase
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	assign pif.busy = (st_r != ST_IDLE);
	assign pif.il_en = out_r[11:0];
	assign pif.dc_en = out_r[25:12];
endmodule : logic_program_runner

// ---- tb/switchgear_model.sv ----
// Switchgear objects 1..7 seen through their status contacts.
// Assumes control pulses are level high while the object should travel.
`timescale 1ns/1ps
module switchgear_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [5:0] open_cmd,
	input  wire logic [5:0] close_cmd,
	output logic      [6:0] closed,
	output logic      [6:0] opened
);
	logic [6:0] pos_r;
	// Objects start closed; object 7 has no drive and never moves
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_r <= 7'h7f;
		end else begin
			pos_r <= (pos_r | {1'b0, close_cmd}) & ~{1'b0, open_cmd};
		end
	end
	assign closed = pos_r;
	assign opened = ~pos_r;
endmodule : switchgear_model

// ---- tb/interlock_logic_engine_checker.sv ----
// Port-level checks of the interlock logic engine.
// Assumes the APB master keeps the setup then access order.
`timescale 1ns/1ps
module ile_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [5:0]  prot_trip,
	input wire logic [5:0]  open_out,
	input wire logic [5:0]  close_out,
	input wire logic        signal_out_a
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic byp_r;
	wire logic wr_w = psel && penable && pwrite;
	// Tracks whether every control operation is enabled regardless of the program
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byp_r <= 1'b0;
		end else if (wr_w && paddr == 12'h000) begin
			byp_r <= pwdata[2] | ~pwdata[1];
		end
	end
	a_trip_passes: assert property ((open_out & prot_trip) == prot_trip)
		else $error("trip not passed to open output");
	a_err_unmapped: assert property (psel && penable && paddr == 12'hffc |-> pslverr)
		else $error("unmapped access without error");
	a_prog_mapped: assert property (psel && penable && paddr inside {12'h400, 12'h590} |-> !pslverr)
		else $error("program line refused");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("access not answered");
	a_open_cmd: assert property (wr_w && paddr == 12'h028 && pwdata[0] && byp_r |-> ##3 open_out[0])
		else $error("enabled open request gave no pulse");
	a_close_cmd: assert property (wr_w && paddr == 12'h028 && pwdata[8] && byp_r |-> ##3 close_out[0])
		else $error("enabled close request gave no pulse");
	a_pulse_hold: assert property ($rose(close_out[0]) |=> close_out[0] [*8])
		else $error("close pulse too short");
	a_reset_quiet: assert property ($rose(presetn) |-> close_out == 6'h00 && !signal_out_a)
		else $error("output active after reset");
endmodule : ile_checker
bind interlock_logic_engine ile_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .prot_trip(prot_trip), .open_out(open_out), .close_out(close_out),
	.signal_out_a(signal_out_a));

// ---- tb/interlock_logic_engine_tb.sv ----
// Self-checking bench of the interlock logic engine.
// Assumes a 10-cycle tick, so a 20 ms pass takes 200 cycles.
`timescale 1ns/1ps
module interlock_logic_engine_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sa, e, kr, sb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, seed, p0, a0;
	logic [9:0]  aux_in;
	logic [5:0]  prot_trip, oo, co, led;
	logic [6:0]  cl, op;
	int          mismatches, num_checks, cyc;
	always #5 pclk = ~pclk;
	interlock_logic_engine #(.TICK_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .obj_closed(cl), .obj_open(op),
		.aux_in(aux_in), .key_remote(kr), .prot_trip(prot_trip), .open_out(oo),
		.close_out(co), .signal_out_a(sa), .signal_out_b(sb), .led_out(led));
	switchgear_model i_gear (.clk(pclk), .rst_n(presetn), .open_cmd(oo), .close_cmd(co),
		.closed(cl), .opened(op));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		num_checks++;
		if (x !== y) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, x, y);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic prog(input logic [15:0] w[8]);
		foreach (w[i]) apb(1'b1, 12'h400 + 12'(4 * i), {16'h0, w[i]});
	endtask : prog
	// Syntax check lasts at most about 102 cycles
	task automatic run(input logic [1:0] x);
		apb(1'b1, 12'h000, 32'h3);
		repeat (110) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("status", x, q[1:0]);
	endtask : run
	task automatic wsig(input logic v);
		repeat (500) begin
			@(posedge pclk);
			if (sa === v) break;
		end
		chk("signal_a", v, sa);
	endtask : wsig
	task automatic cmd(input logic [31:0] d);
		apb(1'b1, 12'h028, d);
		repeat (3) @(posedge pclk);
	endtask : cmd
	function automatic logic [31:0] actv(input logic [9:0] a, input logic [9:0] p);
		return {22'h0, ~(a ^ p)};
	endfunction : actv
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task final_report;
		if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			final_report;
		end
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, prot_trip, aux_in, kr} = '0;
		seed = 32'h5d2121ce;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl", 32'h2, q);
		apb(1'b0, 12'h008, 32'h0);
		chk("polarity", 32'h3ff, q);
		apb(1'b0, 12'h590, 32'h0);
		chk("line_300", 32'h0, q);
		apb(1'b0, 12'hffc, 32'h0);
		chk("unmapped_err", 32'h1, e);
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b1, 12'h018, 32'h1);
		prog('{0: 16'h7014, default: 16'h0});
		run(2'b10);
		// Open 1 always enabled; signal a = channel 8 or key via temp 70
		prog('{16'h103d, 16'h7014, 16'h1008, 16'h503e, 16'h7046, 16'h1046, 16'h7028, 16'h0});
		apb(1'b0, 12'h408, 32'h0);
		chk("line_202", 32'h1008, q);
		run(2'b01);
		apb(1'b1, 12'h400, 32'h0);
		apb(1'b0, 12'h400, 32'h0);
		chk("line_locked", 32'h103d, q);
		aux_in <= 10'h001;
		wsig(1'b1);
		aux_in <= 10'h000;
		wsig(1'b0);
		kr <= 1'b1;
		wsig(1'b1);
		kr <= 1'b0;
		wsig(1'b0);
		cmd(32'h101);
		chk("open_1", 32'h1, oo[0]);
		chk("close_1", 32'h0, co[0]);
		repeat (900) @(posedge pclk);
		chk("open_1_hold", 32'h1, oo[0]);
		repeat (200) @(posedge pclk);
		chk("open_1_end", 32'h0, oo[0]);
		apb(1'b1, 12'h000, 32'h6);
		cmd(32'h100);
		chk("close_bypass", 32'h1, co[0]);
		apb(1'b1, 12'h000, 32'h0);
		cmd(32'h200);
		chk("close_il_off", 32'h1, co[1]);
		prot_trip <= 6'h20;
		@(posedge pclk);
		chk("trip", 32'h1, oo[5]);
		prot_trip <= 6'h00;
		apb(1'b1, 12'h040, 32'h29);
		repeat (6) begin
			seed = nx(seed);
			p0 = seed;
			apb(1'b1, 12'h008, {22'h0, p0[9:0]});
			repeat (3) @(posedge pclk);
			apb(1'b1, 12'h01c, 32'h3ff);
			a0 = {22'h0, aux_in};
			seed = nx(seed);
			aux_in <= seed[9:0];
			repeat (3) @(posedge pclk);
			apb(1'b0, 12'h020, 32'h0);
			chk("instate", actv(seed[9:0], p0[9:0]), {22'h0, q[9:0]});
			chk("leds", actv(seed[9:0], p0[9:0]) & 32'h3f, {26'h0, led});
			chk("signal_b", actv(seed[9:0], p0[9:0]) & 32'h1, {31'h0, sb});
			apb(1'b0, 12'h01c, 32'h0);
			chk("event", actv(a0[9:0], p0[9:0]) ^ actv(seed[9:0], p0[9:0]), q);
		end
		final_report;
	end
endmodule : interlock_logic_engine_tb
